// *** dma_stream_control.sv ***
// Multi-stream DMA engine: stream registers, arbiter and port sequencer
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dma_stream_control
(
	// Clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  resetn_in,
	// Register port
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic [31:0]           reg_wdata_in,
	input  wire logic                  reg_write_in,
	input  wire logic                  reg_read_in,
	output logic      [31:0]           reg_rdata_out,
	// Peripheral requests
	input  wire logic [1:0]            periph_dreq_in,
	// Direct peripheral port
	output var dma_pkg::xfer_bus_type  periph_bus_out,
	input  wire logic [31:0]           periph_rdata_in,
	// Memory port
	output var dma_pkg::xfer_bus_type  mem_bus_out,
	input  wire logic [31:0]           mem_rdata_in,
	input  wire logic                  sram_foreign_access_in
);
	localparam int N = dma_pkg::NUM_STREAMS;
	localparam int CW = dma_pkg::COUNT_W;
	localparam int SW = dma_pkg::SEL_W;

	dma_pkg::stream_cfg_type cfg_reg [N], cfg_next [N];
	logic [CW-1:0] count_reg [N], count_next [N];
	logic [CW-1:0] last_count_reg [N], last_count_next [N];
	logic [CW-1:0] src_left_reg [N], src_left_next [N];
	logic [31:0]   paddr_reg [N], paddr_next [N];
	logic [31:0]   maddr_reg [N], maddr_next [N];
	logic [31:0]   cur_paddr_reg [N], cur_paddr_next [N];
	logic [31:0]   cur_maddr_reg [N], cur_maddr_next [N];
	logic [N-1:0]  on_reg, on_next, stop_reg, stop_next;
	logic [N-1:0]  tc_reg, tc_next, fe_reg, fe_next;
	logic [N-1:0]  tc_set, fe_set, want_m, want_p;
	logic [N-1:0]  fifo_push, fifo_pop, fifo_flush;
	logic [31:0]   fifo_head [N];
	logic [2:0]    fifo_level [N];
	logic [31:0]   push_data;
	dma_pkg::state_type state_reg, state_next;
	logic [SW-1:0] sel_reg, sel_next, pick_s, reg_s;
	logic          pick_valid, pick_mem, reg_hit, run_s;
	logic [1:0]    xfer_reg, xfer_next;
	logic [31:0]   data_reg, data_next, rdata_reg, rdata_next;
	logic          foreign_reg, foreign_next, lock_reg, lock_next;
	logic          mem_write_reg, mem_write_next;
	logic [2:0]    burst_reg, burst_next;
	dma_pkg::xfer_bus_type pbus_reg, pbus_next, mbus_reg, mbus_next;
	dma_pkg::stream_cfg_type cs;

	function automatic logic [2:0] f_cap(dma_pkg::stream_cfg_type c);
		return c.fifo_mode ? dma_pkg::FIFO_DEPTH : dma_pkg::DIRECT_DEPTH;
	endfunction

	function automatic logic [2:0] f_thresh(dma_pkg::stream_cfg_type c);
		return {1'b0, c.thresh} + 3'h1;
	endfunction

	function automatic logic f_flush(dma_pkg::stream_cfg_type c,
		logic [2:0] lvl, logic [CW-1:0] left);
		return lvl != 3'h0
			&& (!c.fifo_mode || lvl >= f_thresh(c) || left == '0);
	endfunction

	for (genvar g = 0; g < N; g++)
	begin : g_fifo
		stream_fifo u_fifo (
			.core_clk_in (core_clk_in),
			.resetn_in   (resetn_in),
			.flush_in    (fifo_flush[g]),
			.push_in     (fifo_push[g]),
			.pop_in      (fifo_pop[g]),
			.data_in     (push_data),
			.head_out    (fifo_head[g]),
			.level_out   (fifo_level[g])
		);
	end

	// Stream arbiter, lowest stream wins, memory side first within a stream
	always_comb
	begin
		pick_valid = 1'b0;
		pick_mem = 1'b0;
		pick_s = '0;
		for (int s = N - 1; s >= 0; s--)
		begin
			run_s = on_reg[s] && !stop_reg[s];
			if (cfg_reg[s].dir == dma_pkg::DIR_M2P)
			begin
				want_m[s] = run_s && src_left_reg[s] != '0
					&& fifo_level[s] < f_cap(cfg_reg[s]);
				want_p[s] = run_s && periph_dreq_in[s] && fifo_level[s] != 3'h0;
			end
			else
			begin
				want_m[s] = run_s
					&& f_flush(cfg_reg[s], fifo_level[s], src_left_reg[s]);
				want_p[s] = run_s && src_left_reg[s] != '0
					&& fifo_level[s] < f_cap(cfg_reg[s])
					&& (periph_dreq_in[s] || cfg_reg[s].dir == dma_pkg::DIR_M2M);
			end
			if (want_m[s] || want_p[s])
			begin
				pick_valid = 1'b1;
				pick_mem = want_m[s];
				pick_s = SW'(s);
			end
		end
		if (lock_reg)
		begin
			pick_valid = 1'b1;
			pick_mem = 1'b1;
			pick_s = sel_reg;
		end
	end

	assign reg_s = reg_addr_in[dma_pkg::STREAM_SHIFT +: SW];
	assign reg_hit = reg_addr_in[7:dma_pkg::STREAM_SHIFT+SW] == '0;
	assign cs = cfg_reg[sel_reg];
	assign push_data = state_reg == dma_pkg::ST_MSRAM ? mem_rdata_in
		: periph_rdata_in;

	always_comb
	begin
		state_next = state_reg;
		sel_next = sel_reg;
		xfer_next = xfer_reg;
		data_next = data_reg;
		lock_next = lock_reg;
		burst_next = burst_reg;
		mem_write_next = mem_write_reg;
		cfg_next = cfg_reg;
		count_next = count_reg;
		last_count_next = last_count_reg;
		src_left_next = src_left_reg;
		paddr_next = paddr_reg;
		maddr_next = maddr_reg;
		cur_paddr_next = cur_paddr_reg;
		cur_maddr_next = cur_maddr_reg;
		on_next = on_reg;
		stop_next = stop_reg;
		fifo_push = '0;
		fifo_pop = '0;
		fifo_flush = '0;
		tc_set = '0;
		fe_set = '0;
		rdata_next = 32'h0;
		foreign_next = (state_reg == dma_pkg::ST_MSRAM ? 1'b0 : foreign_reg)
			|| sram_foreign_access_in;
		unique case (state_reg)
			dma_pkg::ST_IDLE:
				if (pick_valid)
				begin
					sel_next = pick_s;
					mem_write_next = cfg_reg[pick_s].dir != dma_pkg::DIR_M2P;
					state_next = pick_mem ? dma_pkg::ST_MADDR : dma_pkg::ST_PADDR;
					if (pick_mem && !lock_reg && mem_write_next
						&& cfg_reg[pick_s].fifo_mode
						&& !(cfg_reg[pick_s].periph_addr_step
						&& cfg_reg[pick_s].mem_addr_step))
					begin
						burst_next = f_thresh(cfg_reg[pick_s]);
						lock_next = burst_next != 3'h1;
					end
				end
			dma_pkg::ST_PADDR:
			begin
				xfer_next = cs.ratio2 ? dma_pkg::XFER_LAST_RATIO2
					: dma_pkg::XFER_LAST_RATIO1;
				if (cs.dir == dma_pkg::DIR_M2P)
				begin
					data_next = fifo_head[sel_reg];
					fifo_pop[sel_reg] = 1'b1;
				end
				state_next = dma_pkg::ST_PXFER;
			end
			dma_pkg::ST_PXFER:
				if (xfer_reg != 2'h0)
					xfer_next = xfer_reg - 2'h1;
				else
				begin
					state_next = dma_pkg::ST_PSYNC;
					if (cs.periph_addr_step)
						cur_paddr_next[sel_reg] = cur_paddr_reg[sel_reg]
							+ dma_pkg::ADDR_STEP;
					if (cs.dir == dma_pkg::DIR_M2P)
						count_next[sel_reg] = count_reg[sel_reg] - CW'(1);
					else
					begin
						fifo_push[sel_reg] = 1'b1;
						src_left_next[sel_reg] = src_left_reg[sel_reg] - CW'(1);
					end
				end
			dma_pkg::ST_PSYNC:
				// direct mode writes right after the read
				if (cs.dir != dma_pkg::DIR_M2P && !cs.fifo_mode)
					state_next = dma_pkg::ST_MARB;
				else if (pick_valid && !pick_mem)
				begin
					sel_next = pick_s;
					mem_write_next = cfg_reg[pick_s].dir != dma_pkg::DIR_M2P;
					state_next = dma_pkg::ST_PADDR;
				end
				else
					state_next = dma_pkg::ST_IDLE;
			dma_pkg::ST_MARB:
				state_next = dma_pkg::ST_MADDR;
			dma_pkg::ST_MADDR:
			begin
				if (mem_write_reg)
				begin
					data_next = fifo_head[sel_reg];
					fifo_pop[sel_reg] = 1'b1;
				end
				state_next = foreign_reg ? dma_pkg::ST_MBUS : dma_pkg::ST_MSRAM;
			end
			dma_pkg::ST_MBUS:
				state_next = dma_pkg::ST_MSRAM;
			dma_pkg::ST_MSRAM:
			begin
				state_next = dma_pkg::ST_IDLE;
				if (cs.mem_addr_step)
					cur_maddr_next[sel_reg] = cur_maddr_reg[sel_reg]
						+ dma_pkg::ADDR_STEP;
				if (mem_write_reg)
					count_next[sel_reg] = count_reg[sel_reg] - CW'(1);
				else
				begin
					fifo_push[sel_reg] = 1'b1;
					src_left_next[sel_reg] = src_left_reg[sel_reg] - CW'(1);
				end
				if (lock_reg)
				begin
					burst_next = burst_reg - 3'h1;
					lock_next = burst_reg > 3'h1
						&& fifo_level[sel_reg] != 3'h0;
				end
			end
		endcase
		for (int s = 0; s < N; s++)
		begin
			// request before the stream is on
			if (cfg_reg[s].dir == dma_pkg::DIR_M2P && !on_reg[s]
				&& periph_dreq_in[s])
				fe_set[s] = 1'b1;
			// stop only once the engine has let go
			if (stop_reg[s] && (state_next == dma_pkg::ST_IDLE
				|| sel_next != SW'(s)) && !lock_next)
			begin
				on_next[s] = 1'b0;
				stop_next[s] = 1'b0;
				tc_set[s] = 1'b1;
				fifo_flush[s] = 1'b1;
			end
			if (on_reg[s] && count_next[s] == '0)
			begin
				on_next[s] = 1'b0;
				stop_next[s] = 1'b0;
				tc_set[s] = 1'b1;
			end
		end
		if (reg_write_in && reg_hit)
			unique case (reg_addr_in[dma_pkg::STREAM_SHIFT-1:0])
				dma_pkg::CTRL_OFS:
					if (!on_reg[reg_s] && reg_wdata_in[dma_pkg::ON_BIT])
					begin
						cfg_next[reg_s] = dma_pkg::stream_cfg_type'(
							reg_wdata_in[dma_pkg::CFG_MSB:dma_pkg::CFG_LSB]);
						on_next[reg_s] = 1'b1;
						count_next[reg_s] = count_reg[reg_s] == '0
							? last_count_reg[reg_s] : count_reg[reg_s];
						src_left_next[reg_s] = count_next[reg_s];
						cur_paddr_next[reg_s] = paddr_reg[reg_s];
						cur_maddr_next[reg_s] = maddr_reg[reg_s];
						fifo_flush[reg_s] = 1'b1;
					end
					else if (!on_reg[reg_s])
						cfg_next[reg_s] = dma_pkg::stream_cfg_type'(
							reg_wdata_in[dma_pkg::CFG_MSB:dma_pkg::CFG_LSB]);
					else if (!reg_wdata_in[dma_pkg::ON_BIT])
						stop_next[reg_s] = 1'b1;
				dma_pkg::COUNT_OFS:
					if (!on_reg[reg_s])
					begin
						count_next[reg_s] = reg_wdata_in[CW-1:0];
						last_count_next[reg_s] = reg_wdata_in[CW-1:0];
					end
				dma_pkg::PADDR_OFS:
					if (!on_reg[reg_s])
						paddr_next[reg_s] = reg_wdata_in;
				dma_pkg::MADDR_OFS:
					if (!on_reg[reg_s])
						maddr_next[reg_s] = reg_wdata_in;
				default:
					;
			endcase
		for (int s = 0; s < N; s++)
		begin
			tc_next[s] = tc_set[s] || (tc_reg[s] && !(reg_write_in
				&& reg_addr_in == dma_pkg::FLAG_CLR_ADDR
				&& reg_wdata_in[s*dma_pkg::FLAG_STRIDE+dma_pkg::TC_BIT]));
			fe_next[s] = fe_set[s] || (fe_reg[s] && !(reg_write_in
				&& reg_addr_in == dma_pkg::FLAG_CLR_ADDR
				&& reg_wdata_in[s*dma_pkg::FLAG_STRIDE+dma_pkg::FE_BIT]));
		end
		if (reg_read_in)
		begin
			if (reg_addr_in == dma_pkg::FLAGS_ADDR)
				for (int s = 0; s < N; s++)
				begin
					rdata_next[s*dma_pkg::FLAG_STRIDE+dma_pkg::TC_BIT] = tc_reg[s];
					rdata_next[s*dma_pkg::FLAG_STRIDE+dma_pkg::FE_BIT] = fe_reg[s];
				end
			else if (reg_hit)
				unique case (reg_addr_in[dma_pkg::STREAM_SHIFT-1:0])
					dma_pkg::CTRL_OFS:
						rdata_next[dma_pkg::CFG_MSB:0] = {cfg_reg[reg_s], on_reg[reg_s]};
					dma_pkg::COUNT_OFS:
						rdata_next[CW-1:0] = count_reg[reg_s];
					dma_pkg::PADDR_OFS:
						rdata_next = paddr_reg[reg_s];
					dma_pkg::MADDR_OFS:
						rdata_next = maddr_reg[reg_s];
					default:
						rdata_next = 32'h0;
				endcase
		end
		// direct path has no shared bus arbitration
		pbus_next.sel = state_next == dma_pkg::ST_PXFER;
		pbus_next.write = cfg_reg[sel_next].dir == dma_pkg::DIR_M2P;
		pbus_next.addr = cur_paddr_next[sel_next];
		pbus_next.wdata = data_next;
		mbus_next.sel = state_next == dma_pkg::ST_MSRAM;
		mbus_next.write = mem_write_next;
		mbus_next.addr = cur_maddr_next[sel_next];
		mbus_next.wdata = data_next;
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_reg <= dma_pkg::ST_IDLE;
			sel_reg <= '0;
			xfer_reg <= 2'h0;
			data_reg <= 32'h0;
			rdata_reg <= 32'h0;
			foreign_reg <= 1'b1;
			lock_reg <= 1'b0;
			burst_reg <= 3'h0;
			mem_write_reg <= 1'b0;
			pbus_reg <= '0;
			mbus_reg <= '0;
			cfg_reg <= '{default: '0};
			count_reg <= '{default: '0};
			last_count_reg <= '{default: '0};
			src_left_reg <= '{default: '0};
			paddr_reg <= '{default: '0};
			maddr_reg <= '{default: '0};
			cur_paddr_reg <= '{default: '0};
			cur_maddr_reg <= '{default: '0};
			on_reg <= '0;
			stop_reg <= '0;
			tc_reg <= '0;
			fe_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			sel_reg <= sel_next;
			xfer_reg <= xfer_next;
			data_reg <= data_next;
			rdata_reg <= rdata_next;
			foreign_reg <= foreign_next;
			lock_reg <= lock_next;
			burst_reg <= burst_next;
			mem_write_reg <= mem_write_next;
			pbus_reg <= pbus_next;
			mbus_reg <= mbus_next;
			cfg_reg <= cfg_next;
			count_reg <= count_next;
			last_count_reg <= last_count_next;
			src_left_reg <= src_left_next;
			paddr_reg <= paddr_next;
			maddr_reg <= maddr_next;
			cur_paddr_reg <= cur_paddr_next;
			cur_maddr_reg <= cur_maddr_next;
			on_reg <= on_next;
			stop_reg <= stop_next;
			tc_reg <= tc_next;
			fe_reg <= fe_next;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign periph_bus_out = pbus_reg;
	assign mem_bus_out = mbus_reg;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	sequence direct_start;
		state_reg == dma_pkg::ST_IDLE && pick_valid && !pick_mem && !lock_reg
		&& cfg_reg[pick_s].dir == dma_pkg::DIR_P2M
		&& !cfg_reg[pick_s].fifo_mode && foreign_reg;
	endsequence

	lat_ratio_one_a: assert property (
		direct_start ##0 !cfg_reg[pick_s].ratio2 |-> ##8 mbus_reg.sel
		&& mbus_reg.write && state_reg == dma_pkg::ST_MSRAM)
		else $error("direct path not nine cycles");
	lat_ratio_two_a: assert property (
		direct_start ##0 cfg_reg[pick_s].ratio2 |-> ##10 mbus_reg.sel
		&& mbus_reg.write && state_reg == dma_pkg::ST_MSRAM)
		else $error("direct path not eleven cycles");
	sram_no_arb_a: assert property (
		state_reg == dma_pkg::ST_MADDR && !foreign_reg |=> mbus_reg.sel)
		else $error("needless arbitration cycle");
	fifo_thresh_a: assert property (
		state_reg == dma_pkg::ST_IDLE && pick_valid && pick_mem && !lock_reg
		&& cs.fifo_mode && cfg_reg[pick_s].dir != dma_pkg::DIR_M2P
		&& src_left_reg[pick_s] != '0 |-> fifo_level[pick_s]
		>= f_thresh(cfg_reg[pick_s]))
		else $error("memory write below threshold");
	sync_overlap_a: assert property (
		state_reg == dma_pkg::ST_PSYNC && cs.dir == dma_pkg::DIR_M2P
		&& pick_valid && !pick_mem |=> state_reg == dma_pkg::ST_PADDR
		##1 pbus_reg.sel)
		else $error("arbitration not overlapped");
	on_hold_a: assert property (
		state_reg == dma_pkg::ST_PXFER && xfer_reg != 2'h0
		&& on_reg[sel_reg]
		|=> on_reg[$past(sel_reg)])
		else $error("stream-on dropped mid transfer");
	stop_done_a: assert property (
		$fell(on_reg[0]) |-> tc_reg[0])
		else $error("stop without transfer done");
	early_req_a: assert property (
		cfg_reg[1].dir == dma_pkg::DIR_M2P && !on_reg[1] && periph_dreq_in[1]
		|=> fe_reg[1])
		else $error("fifo fault not raised");
	count_reload_a: assert property (
		reg_write_in && reg_hit && reg_s == '0 && !on_reg[0]
		&& reg_addr_in[dma_pkg::STREAM_SHIFT-1:0] == dma_pkg::CTRL_OFS
		&& reg_wdata_in[dma_pkg::ON_BIT] && count_reg[0] == '0
		|=> count_reg[0] == $past(last_count_reg[0]))
		else $error("count not reloaded");
	burst_lock_a: assert property (
		lock_reg && state_reg == dma_pkg::ST_IDLE
		|=> state_reg == dma_pkg::ST_MADDR && $stable(sel_reg))
		else $error("locked burst interrupted");

	direct_c: cover property (direct_start ##8 mbus_reg.sel);
	overlap_c: cover property (state_reg == dma_pkg::ST_PSYNC
		##1 state_reg == dma_pkg::ST_PADDR);
	stop_c: cover property (stop_reg[0] ##[1:20] $fell(on_reg[0]));
	lock_c: cover property (lock_reg ##1 !lock_reg);
endmodule
`default_nettype wire

// *** dma_pkg.sv ***
// Shared constants and types for the stream DMA controller
// Notes on behaviour
// - Direct peripheral read to SRAM write takes 9 cycles, 11 at ratio two.
// - With the FIFO in use, memory writes start at the threshold fill, or below it once the source count is used up.
// - No arbitration cycle when no other master used SRAM since our access.
// - Memory-to-peripheral prefetches into the FIFO before the trigger arrives.
// - A pending request's arbitration overlaps the current sync cycle.
// - Direct peripheral path latency ignores CPU traffic elsewhere.
// - Stream-on bit reads one until the stream has really stopped.
// - Disabling an active stream sets its transfer-done flag.
// - Memory-to-peripheral request before enable sets the FIFO fault flag.
// - Count at zero sets transfer-done; re-enable reloads the last count.
// - Non-incrementing bursts are not interrupted by other streams.
// - After an early stop the count holds the untransferred items.
// - Each stream has a FIFO of four 32-bit words.
// - Peripheral side runs on requests except in memory-to-memory mode, memory side on threshold or direct; memory-to-peripheral reads run on FIFO room.
`default_nettype none
package dma_pkg;
	localparam int NUM_STREAMS = 2;
	localparam int SEL_W = 1;
	localparam int COUNT_W = 16;
	localparam int FIFO_WORDS = 4;
	localparam logic [2:0] FIFO_DEPTH = 3'h4;
	localparam logic [2:0] DIRECT_DEPTH = 3'h1;
	// Register map
	localparam int STREAM_SHIFT = 5;
	localparam logic [4:0] CTRL_OFS = 5'h00;
	localparam logic [4:0] COUNT_OFS = 5'h04;
	localparam logic [4:0] PADDR_OFS = 5'h08;
	localparam logic [4:0] MADDR_OFS = 5'h0C;
	localparam logic [7:0] FLAGS_ADDR = 8'h40;
	localparam logic [7:0] FLAG_CLR_ADDR = 8'h44;
	// Control and flag fields
	localparam int ON_BIT = 0;
	localparam int CFG_LSB = 1;
	localparam int CFG_MSB = 8;
	localparam int FLAG_STRIDE = 4;
	localparam int TC_BIT = 0;
	localparam int FE_BIT = 1;
	localparam logic [31:0] ADDR_STEP = 32'h4;
	// Effective transfer cycles minus one, per clock ratio
	localparam logic [1:0] XFER_LAST_RATIO1 = 2'h1;
	localparam logic [1:0] XFER_LAST_RATIO2 = 2'h3;

	typedef enum logic [1:0] {DIR_P2M, DIR_M2P, DIR_M2M} dir_type;

	typedef struct packed {
		logic       ratio2;
		logic       mem_addr_step;
		logic       periph_addr_step;
		logic [1:0] thresh;
		logic       fifo_mode;
		dir_type    dir;
	} stream_cfg_type;

	typedef struct packed {
		logic        sel;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} xfer_bus_type;

	typedef enum logic [2:0] {
		ST_IDLE, ST_PADDR, ST_PXFER, ST_PSYNC,
		ST_MARB, ST_MADDR, ST_MBUS, ST_MSRAM
	} state_type;
endpackage
`default_nettype wire

// *** stream_fifo.sv ***
// Four-word per-stream data FIFO
`timescale 1ns/1ps
`default_nettype none
module stream_fifo
(
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// Control
	input  wire logic        flush_in,
	input  wire logic        push_in,
	input  wire logic        pop_in,
	input  wire logic [31:0] data_in,
	// Status
	output logic      [31:0] head_out,
	output logic      [2:0]  level_out
);
	logic [31:0] mem_reg  [dma_pkg::FIFO_WORDS];
	logic [31:0] mem_next [dma_pkg::FIFO_WORDS];
	logic [1:0]  rd_reg;
	logic [1:0]  rd_next;
	logic [1:0]  wr_reg;
	logic [1:0]  wr_next;
	logic [2:0]  level_reg;
	logic [2:0]  level_next;
	logic        push_ok;
	logic        pop_ok;

	always_comb
	begin
		push_ok = push_in && level_reg != dma_pkg::FIFO_DEPTH;
		pop_ok = pop_in && level_reg != 3'h0;
		mem_next = mem_reg;
		rd_next = rd_reg;
		wr_next = wr_reg;
		level_next = level_reg;
		if (flush_in)
		begin
			rd_next = 2'h0;
			wr_next = 2'h0;
			level_next = 3'h0;
		end
		else
		begin
			if (push_ok)
			begin
				mem_next[wr_reg] = data_in;
				wr_next = wr_reg + 2'h1;
			end
			if (pop_ok)
				rd_next = rd_reg + 2'h1;
			level_next = level_reg + {2'h0, push_ok} - {2'h0, pop_ok};
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			mem_reg <= '{default: '0};
			rd_reg <= 2'h0;
			wr_reg <= 2'h0;
			level_reg <= 3'h0;
		end
		else
		begin
			mem_reg <= mem_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			level_reg <= level_next;
		end
	end

	assign head_out = mem_reg[rd_reg];
	assign level_out = level_reg;

	fifo_bound_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		level_reg <= dma_pkg::FIFO_DEPTH)
		else $error("fifo level above four words");
endmodule
`default_nettype wire

// *** far_side_model.sv ***
// Peripheral and SRAM data model for the engine's far side
`timescale 1ns/1ps
`default_nettype none
module far_side_model
(
	// Clock
	input  wire logic                  core_clk_in,
	// Engine ports
	input  wire dma_pkg::xfer_bus_type periph_bus_in,
	input  wire dma_pkg::xfer_bus_type mem_bus_in,
	// Read data back
	output logic      [31:0]           periph_rdata_out,
	output logic      [31:0]           mem_rdata_out
);
	logic [31:0] churn_reg = 32'h1;

	// Released lines change every cycle
	always_ff @(posedge core_clk_in)
		churn_reg <= churn_reg + 32'h9E3779B9;
	assign periph_rdata_out = periph_bus_in.sel ?
		(periph_bus_in.addr ^ 32'h5A000000) : churn_reg;
	assign mem_rdata_out = mem_bus_in.sel ?
		(mem_bus_in.addr ^ 32'h00C30000) : churn_reg;
endmodule
`default_nettype wire

// *** dma_stream_control_bench.sv ***
// Self-checking bench for the stream DMA engine
`timescale 1ns/1ps
`default_nettype none
module dma_stream_control_bench;
	typedef struct {logic [31:0] ctrl; logic foreign; int cycles;} row_type;
	row_type rows [4] = '{'{32'h1, 1'b1, 8}, '{32'h1, 1'b0, 7},
		'{32'h101, 1'b1, 10}, '{32'h101, 1'b0, 9}};
	logic core_clk;
	logic resetn;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [31:0] reg_rdata;
	logic [1:0] dreq;
	logic foreign;
	logic [31:0] p_rdata;
	logic [31:0] m_rdata;
	dma_pkg::xfer_bus_type p_bus;
	dma_pkg::xfer_bus_type m_bus;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int mw = 0;
	int mr = 0;
	int n;
	logic [31:0] d;

	dma_stream_control dut_u (.core_clk_in(core_clk), .resetn_in(resetn),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_write_in(reg_write), .reg_read_in(reg_read),
		.reg_rdata_out(reg_rdata), .periph_dreq_in(dreq),
		.periph_bus_out(p_bus), .periph_rdata_in(p_rdata),
		.mem_bus_out(m_bus), .mem_rdata_in(m_rdata),
		.sram_foreign_access_in(foreign));
	far_side_model far_u (.core_clk_in(core_clk), .periph_bus_in(p_bus),
		.mem_bus_in(m_bus), .periph_rdata_out(p_rdata),
		.mem_rdata_out(m_rdata));

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		cycles++;
		if (m_bus.sel === 1'b1)
		begin
			if (m_bus.write === 1'b1)
				mw++;
			else
				mr++;
		end
		if (cycles == 20000)
		begin
			errors++;
			complete_run();
		end
	end

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			errors++;
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(logic [7:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask

	// One request pulse, then time for the item to land
	task automatic req(logic [1:0] m);
		dreq <= m;
		@(posedge core_clk);
		dreq <= 2'h0;
		repeat (12) @(posedge core_clk);
	endtask

	task automatic wait_off(logic [7:0] base);
		d = 32'h1;
		for (int k = 0; k < 100 && d[0] !== 1'b0; k++) rd(base);
		chk("stream on bit", d & 32'h1, 32'h0);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		{resetn, reg_addr, reg_wdata, reg_write, reg_read} = '0;
		{dreq, foreign} = '0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h08, 32'h100 + i * 16);
			wr(8'h04, 32'h1);
			foreign <= rows[i].foreign;
			@(posedge core_clk);
			foreign <= 1'b0;
			wr(8'h00, rows[i].ctrl);
			dreq <= 2'h1;
			@(posedge core_clk);
			dreq <= 2'h0;
			n = 1;
			#1;
			while (m_bus.sel !== 1'b1 && n < 40)
			begin
				@(posedge core_clk);
				n++;
				#1;
			end
			chk("trigger to sram cycles", n, rows[i].cycles);
			chk("sram word", m_bus.wdata, (32'h100 + i * 16) ^ 32'h5A000000);
			@(posedge core_clk);
			wait_off(8'h00);
			rd(8'h40);
			chk("done flag", d, 32'h1);
			wr(8'h44, 32'hFF);
			$display("Latency row %0d done", i);
		end
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h1);
		dreq <= 2'h1;
		@(posedge core_clk);
		dreq <= 2'h0;
		repeat (14) @(posedge core_clk);
		wr(8'h00, 32'h0);
		wait_off(8'h00);
		rd(8'h04);
		chk("items left", d, 32'h2);
		wr(8'h44, 32'h0);
		rd(8'h40);
		chk("done after stop", d, 32'h1);
		wr(8'h44, 32'h1);
		rd(8'h40);
		chk("flags cleared", d, 32'h0);
		// resume with new pointer and count
		n = mw;
		wr(8'h08, 32'h300);
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h1);
		req(2'h1);
		req(2'h1);
		wait_off(8'h00);
		chk("resume writes", mw - n, 32'h2);
		wr(8'h44, 32'h1);
		$display("Early stop done");
		wr(8'h20, 32'h2);
		dreq <= 2'h2;
		@(posedge core_clk);
		dreq <= 2'h0;
		rd(8'h40);
		chk("fifo fault", d, 32'h20);
		wr(8'h44, 32'h20);
		$display("Early request done");
		n = mw;
		wr(8'h04, 32'h2);
		wr(8'h00, 32'h5);
		wait_off(8'h00);
		rd(8'h04);
		chk("copy count", d, 32'h0);
		wr(8'h44, 32'h1);
		wr(8'h00, 32'h5);
		wait_off(8'h00);
		chk("copy writes", mw - n, 32'h4);
		$display("Memory copy done");
		n = mr;
		wr(8'h28, 32'h600);
		wr(8'h2C, 32'h3000);
		wr(8'h24, 32'h1);
		wr(8'h20, 32'h3);
		repeat (12) @(posedge core_clk);
		chk("prefetch reads", mr - n, 32'h1);
		dreq <= 2'h2;
		@(posedge core_clk);
		dreq <= 2'h0;
		#1;
		for (int k = 0; k < 20 && p_bus.sel !== 1'b1; k++)
		begin
			@(posedge core_clk);
			#1;
		end
		chk("periph word", p_bus.wdata, 32'h00C33000);
		chk("periph write", p_bus.write, 32'h1);
		$display("Prefetch done");
		@(posedge core_clk);
		wr(8'h44, 32'h3);
		n = mw;
		wr(8'h08, 32'h200);
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h59);
		req(2'h1);
		chk("below threshold", mw - n, 32'h0);
		req(2'h1);
		chk("burst writes", mw - n, 32'h2);
		req(2'h1);
		wait_off(8'h00);
		chk("flush writes", mw - n, 32'h3);
		$display("Fifo burst done");
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		foreach (rows[i])
		begin
			rd(8'h20 * 8'(i));
			chk("reset value", d, 32'h0);
		end
		$display("Reset done");
		complete_run();
	end
endmodule
`default_nettype wire
